/* inc/etm_consts.svh */
`ifndef ETM_CONSTS_SVH
`define ETM_CONSTS_SVH
`define ETM_CLK_KHZ    10000
`define ETM_LINE_KBPS  10000
`define ETM_SEC_MS     1000
`define ETM_JABBER_MS  20
`define ETM_LINK_TX_MS 16
`define ETM_LINK_TO_MS 100
`define ETM_RUNT_BITS  512
`define ETM_TONE_HALF  2500
`define ETM_PCT_FULL   100
`define ETM_BAR_SEGS   10
`define ETM_BAR_STEP   5
`define ETM_HIST_AW    8
`define ETM_DIV_W      32
`define ETM_HMS_LAST   6'h3B
`endif

/* inc/etm_pkg.sv */
package etm_pkg;
  typedef enum logic [2:0] {
    ETM_IDLE  = 3'b001,
    ETM_CLEAR = 3'b010,
    ETM_RUN   = 3'b100
  } etm_state_t;

  typedef enum logic [1:0] {
    ETM_ERR_NONE   = 2'h0,
    ETM_ERR_NOLINK = 2'h1,
    ETM_ERR_POL    = 2'h2,
    ETM_ERR_JABBER = 2'h3
  } etm_err_kind_t;

  typedef struct packed {
    logic [7:0] h;
    logic [5:0] m;
    logic [5:0] s;
  } etm_hms_t;

  typedef struct packed {
    etm_err_kind_t kind;
    logic          active;
    etm_hms_t      hms;
  } etm_err_t;

  typedef struct packed {
    logic [6:0]  util;
    logic [6:0]  peak;
    logic [6:0]  avg;
    logic [6:0]  coll;
    logic [31:0] pkts;
    logic [15:0] jabbers;
    logic [15:0] seconds;
  } etm_result_t;
endpackage : etm_pkg

/* logic/etm_div.sv */
`include "etm_consts.svh"
module etm_div (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  start,
  input  wire logic [`ETM_DIV_W-1:0] num,
  input  wire logic [`ETM_DIV_W-1:0] den,
  output logic                       done_q,
  output logic      [`ETM_DIV_W-1:0] quot_q
);
  logic [`ETM_DIV_W:0]   rem_q, rem_d, rem_sh;
  logic [`ETM_DIV_W-1:0] quot_d, den_q, den_d;
  logic [5:0]            cnt_q, cnt_d;
  logic                  done_d;

  // restoring divide, one quotient bit per cycle; divide by zero gives zero
  always_comb begin
    rem_d  = rem_q;
    quot_d = quot_q;
    den_d  = den_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    rem_sh = {rem_q[`ETM_DIV_W-1:0], quot_q[`ETM_DIV_W-1]};
    if (start) begin
      rem_d  = '0;
      den_d  = den;
      quot_d = (den == '0) ? '0 : num;
      cnt_d  = (den == '0) ? 6'h00 : 6'(`ETM_DIV_W);
      done_d = (den == '0);
    end else if (cnt_q != 6'h00) begin
      quot_d = {quot_q[`ETM_DIV_W-2:0], 1'b0};
      if (rem_sh >= {1'b0, den_q}) begin
        rem_d     = rem_sh - {1'b0, den_q};
        quot_d[0] = 1'b1;
      end else begin
        rem_d = rem_sh;
      end
      cnt_d  = cnt_q - 6'h01;
      done_d = (cnt_q == 6'h01);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rem_q  <= '0;
      quot_q <= '0;
      den_q  <= '0;
      cnt_q  <= 6'h00;
      done_q <= 1'b0;
    end else begin
      rem_q  <= rem_d;
      quot_q <= quot_d;
      den_q  <= den_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end
endmodule : etm_div

/* logic/etm_hist_mem.sv */
`include "etm_consts.svh"
module etm_hist_mem (
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic                    we,
  input  wire logic [`ETM_HIST_AW-1:0] waddr,
  input  wire logic [6:0]              wdata,
  input  wire logic [`ETM_HIST_AW-1:0] raddr,
  output logic      [6:0]              rdata_q
);
  logic [6:0] mem [0:(1<<`ETM_HIST_AW)-1];

  // array has no reset: only entries below the seconds count are meaningful
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 7'h00;
    end else begin
      rdata_q <= mem[raddr];
    end
  end
endmodule : etm_hist_mem

/* logic/etm_monitor.sv */
// Functional notes
// R1: utilization percent is averaged over each most recent one-second window
// R2: peak holds the largest one-second utilization since the test started
// R3: collision rate is collisions over packets in the last second, in percent
// R4: every frame shorter than the minimum length counts as one collision, unless it ends in the cycle that closes a second
// R5: a transmission longer than 20 ms raises the jabber error
// R6: link pulses are sent toward the hub by the monitor itself
// R7: each loss of the established link gives a one-cycle event
// R8: missing link pulses from the hub flag the no-link error
// R9: a reversed receive pair flags the wrong-polarity error
// R10: bar graph is linear, empty at zero, full at 50 percent
// R11: a cleared error shows its kind and time elapsed since it ended
// R12: a present error shows its kind and the time it started
// R13: start clears all stored results, then a new measurement begins; the history array is not cleared, only res_q and the error state
// R14: power-down is held off for as long as the test runs
// R15: history, average, peak, collisions, packets and jabbers stay after the test
// R16: an activity tone sounds while monitoring
// R17: the activity tone is forced off when audible tones are disabled
// R18: utilization is carrier-busy bit times per second at 10 Mb/s
`include "etm_consts.svh"
module etm_monitor #(
  parameter int SEC_CYC = `ETM_SEC_MS * `ETM_CLK_KHZ,
  parameter int JAB_CYC = `ETM_JABBER_MS * `ETM_CLK_KHZ,
  parameter int LTX_CYC = `ETM_LINK_TX_MS * `ETM_CLK_KHZ,
  parameter int LTO_CYC = `ETM_LINK_TO_MS * `ETM_CLK_KHZ
) (
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic                    start_cmd,
  input  wire logic                    stop_cmd,
  input  wire logic                    tone_en,
  input  wire logic                    audible_en,
  input  wire logic                    carrier,
  input  wire logic                    link_pulse,
  input  wire logic                    pulse_inverted,
  input  wire logic [`ETM_HIST_AW-1:0] hist_raddr,
  output logic                         pwr_hold_q,
  output logic                         link_tx_q,
  output logic                         link_lost_q,
  output logic                         tone_q,
  output logic      [`ETM_BAR_SEGS-1:0] bar_q,
  output etm_pkg::etm_result_t         res_q,
  output etm_pkg::etm_err_t            err_q,
  output logic      [6:0]              hist_rdata_q
);
  localparam int PCT_CYC  = SEC_CYC / `ETM_PCT_FULL;
  localparam int RUNT_CYC = `ETM_RUNT_BITS * `ETM_CLK_KHZ / `ETM_LINE_KBPS;

  etm_pkg::etm_state_t  state_q, state_d;
  etm_pkg::etm_result_t res_d;
  etm_pkg::etm_err_t    err_d;
  etm_pkg::etm_hms_t    now_q, now_d;
  etm_pkg::etm_err_kind_t kind_now;
  logic [23:0] sec_cnt_q, sec_cnt_d, pct_sub_q, pct_sub_d, len_q, len_d;
  logic [23:0] ltx_cnt_q, ltx_cnt_d, lto_cnt_q, lto_cnt_d;
  logic [6:0]  pct_acc_q, pct_acc_d;
  logic [15:0] pkts_sec_q, pkts_sec_d, coll_sec_q, coll_sec_d;
  logic [31:0] util_sum_q, util_sum_d;
  logic [11:0] tone_cnt_q, tone_cnt_d;
  logic [`ETM_BAR_SEGS-1:0] bar_d;
  logic car_q, link_up_q, link_up_d, pol_err_q, pol_err_d, jab_err_q, jab_err_d;
  logic link_tx_d, link_lost_d, tone_d, pwr_hold_d;
  logic run, tick, frame_end, any_err;
  logic coll_done, avg_done;
  logic [31:0] coll_quot, avg_quot;

  etm_hist_mem u_hist (
    .clock   (clock),
    .resetn  (resetn),
    .we      (tick),
    .waddr   (res_q.seconds[`ETM_HIST_AW-1:0]),
    .wdata   (pct_acc_q),
    .raddr   (hist_raddr),
    .rdata_q (hist_rdata_q)
  );

  etm_div u_coll_div (
    .clock  (clock),
    .resetn (resetn),
    .start  (tick),
    .num    (32'(coll_sec_q) * 32'(`ETM_PCT_FULL)),
    .den    (32'(pkts_sec_q)),
    .done_q (coll_done),
    .quot_q (coll_quot)
  );

  etm_div u_avg_div (
    .clock  (clock),
    .resetn (resetn),
    .start  (tick),
    .num    (util_sum_q + 32'(pct_acc_q)),
    .den    (32'(res_q.seconds) + 32'h0000_0001),
    .done_q (avg_done),
    .quot_q (avg_quot)
  );

  function automatic etm_pkg::etm_hms_t hms_inc(input etm_pkg::etm_hms_t t);
    etm_pkg::etm_hms_t r;
    r = t;
    if (t.s == `ETM_HMS_LAST) begin
      r.s = 6'h00;
      if (t.m == `ETM_HMS_LAST) begin
        r.m = 6'h00;
        r.h = t.h + 8'h01;
      end else begin
        r.m = t.m + 6'h01;
      end
    end else begin
      r.s = t.s + 6'h01;
    end
    return r;
  endfunction : hms_inc

  assign run       = (state_q == etm_pkg::ETM_RUN);
  assign tick      = run && (sec_cnt_q == 24'(SEC_CYC - 1));
  assign frame_end = run && car_q && !carrier;
  assign any_err   = jab_err_q || pol_err_q || !link_up_q;

  // jabber outranks polarity, which outranks a missing link
  always_comb begin
    if (jab_err_q) begin
      kind_now = etm_pkg::ETM_ERR_JABBER;
    end else if (pol_err_q) begin
      kind_now = etm_pkg::ETM_ERR_POL;
    end else if (!link_up_q) begin
      kind_now = etm_pkg::ETM_ERR_NOLINK;
    end else begin
      kind_now = etm_pkg::ETM_ERR_NONE;
    end
  end

  for (genvar i = 0; i < `ETM_BAR_SEGS; i++) begin : g_bar
    assign bar_d[i] = (res_d.util >= 7'((i + 1) * `ETM_BAR_STEP)); // R10
  end

  always_comb begin
    state_d     = state_q;
    res_d       = res_q;
    err_d       = err_q;
    now_d       = now_q;
    sec_cnt_d   = sec_cnt_q;
    pct_sub_d   = pct_sub_q;
    pct_acc_d   = pct_acc_q;
    len_d       = len_q;
    pkts_sec_d  = pkts_sec_q;
    coll_sec_d  = coll_sec_q;
    util_sum_d  = util_sum_q;
    ltx_cnt_d   = ltx_cnt_q;
    lto_cnt_d   = lto_cnt_q;
    link_up_d   = link_up_q;
    pol_err_d   = pol_err_q;
    jab_err_d   = jab_err_q;
    link_tx_d   = 1'b0;
    link_lost_d = 1'b0;
    tone_cnt_d  = tone_cnt_q;
    tone_d      = tone_q;
    case (state_q)
      etm_pkg::ETM_IDLE: begin
        if (start_cmd) begin
          state_d = etm_pkg::ETM_CLEAR;
        end
      end
      etm_pkg::ETM_CLEAR: begin
        res_d      = '0; // R13
        err_d      = '0;
        now_d      = '0;
        sec_cnt_d  = '0;
        pct_sub_d  = '0;
        pct_acc_d  = '0;
        pkts_sec_d = '0;
        coll_sec_d = '0;
        util_sum_d = '0;
        link_up_d  = 1'b1;
        pol_err_d  = 1'b0;
        jab_err_d  = 1'b0;
        lto_cnt_d  = '0;
        state_d    = etm_pkg::ETM_RUN; // R13
      end
      etm_pkg::ETM_RUN: begin
        if (stop_cmd) begin
          state_d = etm_pkg::ETM_IDLE; // R15
        end
        sec_cnt_d = tick ? 24'h000000 : sec_cnt_q + 24'h000001;
        if (carrier) begin
          // one clock is one bit time, so busy cycles are busy bits
          if (pct_sub_q == 24'(PCT_CYC - 1)) begin
            pct_sub_d = '0;
            pct_acc_d = pct_acc_q + 7'h01; // R18
          end else begin
            pct_sub_d = pct_sub_q + 24'h000001; // R18
          end
          if (len_q <= 24'(JAB_CYC)) begin
            len_d = len_q + 24'h000001;
          end
          if (len_q == 24'(JAB_CYC) && !jab_err_q) begin
            jab_err_d     = 1'b1; // R5
            res_d.jabbers = res_q.jabbers + 16'h0001;
          end
        end else begin
          len_d     = '0;
          jab_err_d = 1'b0;
        end
        if (frame_end) begin
          pkts_sec_d = pkts_sec_q + 16'h0001;
          res_d.pkts = res_q.pkts + 32'h0000_0001;
          if (len_q < 24'(RUNT_CYC)) begin
            coll_sec_d = coll_sec_q + 16'h0001; // R4
          end
        end
        if (tick) begin
          res_d.util    = pct_acc_q; // R1
          res_d.peak    = (pct_acc_q > res_q.peak) ? pct_acc_q : res_q.peak; // R2
          res_d.seconds = res_q.seconds + 16'h0001; // R15
          util_sum_d    = util_sum_q + 32'(pct_acc_q);
          pct_acc_d     = '0;
          pct_sub_d     = '0;
          pkts_sec_d    = '0;
          coll_sec_d    = '0;
          now_d         = hms_inc(now_q);
        end
        if (coll_done) begin
          res_d.coll = coll_quot[6:0]; // R3
        end
        if (avg_done) begin
          res_d.avg = avg_quot[6:0]; // R15
        end
        // own link pulses keep the hub port active
        if (ltx_cnt_q == 24'(LTX_CYC - 1)) begin
          ltx_cnt_d = '0;
          link_tx_d = 1'b1; // R6
        end else begin
          ltx_cnt_d = ltx_cnt_q + 24'h000001;
        end
        if (link_pulse || carrier) begin
          lto_cnt_d = '0;
          link_up_d = 1'b1;
        end else if (lto_cnt_q == 24'(LTO_CYC - 1)) begin
          link_up_d   = 1'b0; // R8
          link_lost_d = link_up_q; // R7
        end else begin
          lto_cnt_d = lto_cnt_q + 24'h000001;
        end
        if (link_pulse) begin
          pol_err_d = pulse_inverted; // R9
        end
        if (any_err && !err_q.active) begin
          err_d.active = 1'b1;
          err_d.kind   = kind_now; // R12
          err_d.hms    = now_q; // R12
        end else if (any_err) begin
          err_d.kind = kind_now;
        end else if (err_q.active) begin
          err_d.active = 1'b0;
          err_d.hms    = '0; // R11
        end else if (tick && err_q.kind != etm_pkg::ETM_ERR_NONE) begin
          err_d.hms = hms_inc(err_q.hms); // R11
        end
      end
      default: begin
        state_d = etm_pkg::ETM_IDLE;
      end
    endcase
    // the tone toggles only while carrier is present, giving an audible buzz
    if (run && carrier) begin
      if (tone_cnt_q == 12'(`ETM_TONE_HALF - 1)) begin
        tone_cnt_d = '0;
        tone_d     = !tone_q; // R16
      end else begin
        tone_cnt_d = tone_cnt_q + 12'h001;
      end
    end else begin
      tone_d = 1'b0;
    end
    if (!(tone_en && audible_en)) begin
      tone_d = 1'b0; // R17
    end
    pwr_hold_d = (state_d != etm_pkg::ETM_IDLE); // R14
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q     <= etm_pkg::ETM_IDLE;
      res_q       <= '0;
      err_q       <= '0;
      now_q       <= '0;
      sec_cnt_q   <= '0;
      pct_sub_q   <= '0;
      pct_acc_q   <= 7'h00;
      len_q       <= '0;
      car_q       <= 1'b0;
      pkts_sec_q  <= 16'h0000;
      coll_sec_q  <= 16'h0000;
      util_sum_q  <= 32'h0000_0000;
      ltx_cnt_q   <= '0;
      lto_cnt_q   <= '0;
      link_up_q   <= 1'b1;
      pol_err_q   <= 1'b0;
      jab_err_q   <= 1'b0;
      link_tx_q   <= 1'b0;
      link_lost_q <= 1'b0;
      tone_cnt_q  <= 12'h000;
      tone_q      <= 1'b0;
      bar_q       <= '0;
      pwr_hold_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      res_q       <= res_d;
      err_q       <= err_d;
      now_q       <= now_d;
      sec_cnt_q   <= sec_cnt_d;
      pct_sub_q   <= pct_sub_d;
      pct_acc_q   <= pct_acc_d;
      len_q       <= len_d;
      car_q       <= carrier;
      pkts_sec_q  <= pkts_sec_d;
      coll_sec_q  <= coll_sec_d;
      util_sum_q  <= util_sum_d;
      ltx_cnt_q   <= ltx_cnt_d;
      lto_cnt_q   <= lto_cnt_d;
      link_up_q   <= link_up_d;
      pol_err_q   <= pol_err_d;
      jab_err_q   <= jab_err_d;
      link_tx_q   <= link_tx_d;
      link_lost_q <= link_lost_d;
      tone_cnt_q  <= tone_cnt_d;
      tone_q      <= tone_d;
      bar_q       <= bar_d;
      pwr_hold_q  <= pwr_hold_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_util_latch: assert property (tick |=> res_q.util == $past(pct_acc_q)) // R1
    else $error("utilization not latched at second end");
  chk_peak_hold: assert property (run && $past(run) |-> res_q.peak >= res_q.util) // R2
    else $error("peak below current utilization");
  chk_runt_coll: assert property (frame_end && !tick && len_q < 24'(RUNT_CYC)
    |=> coll_sec_q == $past(coll_sec_q) + 16'h0001) // R4
    else $error("runt frame not counted as collision");
  chk_jabber_set: assert property (run && carrier && len_q == 24'(JAB_CYC)
    |=> jab_err_q ##1 (jab_err_q || !$past(carrier))) // R5
    else $error("jabber not raised after long transmission");
  chk_link_event: assert property ($fell(link_up_q) && $past(run) |-> link_lost_q) // R7
    else $error("link loss gave no event");
  chk_nolink_flag: assert property (run && !link_up_q && !stop_cmd
    |=> err_q.active && err_q.kind != etm_pkg::ETM_ERR_NONE) // R8
    else $error("missing link not flagged");
  chk_start_clear: assert property (state_q == etm_pkg::ETM_CLEAR
    |=> res_q.pkts == 32'h0000_0000 && res_q.seconds == 16'h0000 && run) // R13
    else $error("start did not clear results");
  chk_pwr_hold: assert property (pwr_hold_q == (state_q != etm_pkg::ETM_IDLE)) // R14
    else $error("power hold does not follow test");
  chk_tone_gate: assert property (!audible_en |=> !tone_q) // R17
    else $error("tone sounded with audible tones off");
  // bar and util register at the same edge, so they are compared in the same cycle
  chk_bar_scale: assert property (res_q.util >= 7'(`ETM_BAR_SEGS * `ETM_BAR_STEP)
    |-> &bar_q) // R10
    else $error("bar graph not full at 50 percent");

  cov_second: cover property (tick ##1 run);
  cov_jabber: cover property ($rose(jab_err_q));
  cov_link_lost: cover property (link_lost_q);
  cov_runt: cover property (frame_end && len_q < 24'(RUNT_CYC));
endmodule : etm_monitor

/* tb/etm_hub_model.sv */
// far side: hub port sending link pulses and frames
module etm_hub_model #(
  parameter int GAP = 100
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic link_on,
  input  wire logic invert,
  output logic      carrier,
  output logic      link_pulse,
  output logic      pulse_inverted
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;

  initial begin
    carrier        = 1'b0;
    link_pulse     = 1'b0;
    pulse_inverted = 1'b0;
  end

  // polarity only means something with a pulse, so it toggles otherwise
  always @(negedge clock) begin
    cnt            = (cnt >= GAP - 1) ? 0 : cnt + 1;
    link_pulse     = resetn && link_on && (cnt == 0);
    pulse_inverted = link_pulse ? invert : ~pulse_inverted;
  end

  task automatic send_frame(input int len);
    @(negedge clock);
    carrier = 1'b1;
    repeat (len) @(negedge clock);
    carrier = 1'b0;
  endtask : send_frame
endmodule : etm_hub_model

/* tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clock      = 1'b0;
  logic                 resetn     = 1'b0;
  logic                 start_cmd;
  logic                 stop_cmd;
  logic                 tone_en;
  logic                 audible_en;
  logic                 link_on;
  logic                 invert;
  logic                 hist_fix;
  logic [7:0]           hist_raddr;
  logic                 carrier;
  logic                 link_pulse;
  logic                 pulse_inverted;
  logic                 pwr_hold_q;
  logic                 link_tx_q;
  logic                 link_lost_q;
  logic                 tone_q;
  logic [9:0]           bar_q;
  etm_pkg::etm_result_t res_q;
  etm_pkg::etm_err_t    err_q;
  logic [6:0]           hist_rdata_q;
  int                   num_errors = 0;
  int                   n_checks   = 0;
  int                   seed       = 32'hd1343d70;
  int                   n_tx, n_lost, n_tone, i;
  int                   id_q[$];
  logic [95:0]          exp_q[$];
  event                 chk_ev;

  always #50 clock = ~clock;
  // a fixed address lets the history contents be checked after the test
  always @(negedge clock) hist_raddr <= hist_fix ? 8'h01 : 8'($random(seed));
  // counted away from the launching edge so each one-cycle pulse is seen once
  always @(negedge clock) begin
    if (link_tx_q === 1'b1) n_tx++;
    if (link_lost_q === 1'b1) n_lost++;
    if (tone_q === 1'b1) n_tone++;
  end

  etm_hub_model hub (.clock(clock), .resetn(resetn), .link_on(link_on), .invert(invert),
    .carrier(carrier), .link_pulse(link_pulse), .pulse_inverted(pulse_inverted));

  etm_monitor #(.SEC_CYC(2000), .JAB_CYC(900), .LTX_CYC(50), .LTO_CYC(400)) dut (
    .clock(clock), .resetn(resetn), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .tone_en(tone_en), .audible_en(audible_en), .carrier(carrier),
    .link_pulse(link_pulse), .pulse_inverted(pulse_inverted), .hist_raddr(hist_raddr),
    .pwr_hold_q(pwr_hold_q), .link_tx_q(link_tx_q), .link_lost_q(link_lost_q),
    .tone_q(tone_q), .bar_q(bar_q), .res_q(res_q), .err_q(err_q),
    .hist_rdata_q(hist_rdata_q));

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [95:0] observe(input int id);
    case (id)
      0: return 96'(pwr_hold_q);
      1: return 96'(res_q.util);
      2: return 96'(res_q.peak);
      3: return 96'(res_q.coll);
      4: return 96'(bar_q);
      5: return 96'(err_q.kind);
      6: return 96'(err_q.active);
      7: return 96'(res_q.jabbers);
      8: return 96'(n_tx);
      9: return 96'(n_lost);
      10: return 96'(n_tone != 0);
      11: return 96'(res_q);
      13: return 96'(hist_rdata_q);
      default: return 96'(err_q.hms.s);
    endcase
  endfunction : observe

  task automatic note(input int id, input logic [95:0] exp);
    id_q.push_back(id);
    exp_q.push_back(exp);
    ->chk_ev;
  endtask : note

  // watcher side: takes every queued note, oldest first, whenever a result is due
  always begin
    @(chk_ev);
    while (id_q.size() != 0) check(observe(id_q.pop_front()), exp_q.pop_front());
  end

  task automatic finish_test();
    #1;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic wait_tick();
    logic [15:0] s0;
    int          k;
    s0 = res_q.seconds;
    for (k = 0; k < 2100 && res_q.seconds === s0; k++) @(negedge clock);
    if (res_q.seconds === s0) begin
      num_errors++;
      finish_test();
    end
  endtask : wait_tick

  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask : settle

  initial begin
    start_cmd  = 1'b0;
    stop_cmd   = 1'b0;
    tone_en    = 1'b1;
    audible_en = 1'b1;
    link_on    = 1'b1;
    invert     = 1'b0;
    hist_fix   = 1'b0;
    settle(6);
    resetn = 1'b1;
    settle(1);
    note(11, '0);
    start_cmd = 1'b1;
    settle(1);
    start_cmd = 1'b0;
    note(0, 1);
    settle(1);
    note(11, '0);
    n_tx = 0;
    settle(201);
    note(8, 4);
    // three full frames and two runts inside one window
    wait_tick();
    for (i = 0; i < 5; i++) begin
      hub.send_frame(i < 3 ? 520 : 100);
      settle(10 + int'($unsigned($random(seed)) % 16));
    end
    wait_tick();
    settle(40);
    note(1, 88);
    note(2, 88);
    note(3, 40);
    note(4, 10'h3FF);
    hub.send_frame(520);
    wait_tick();
    settle(40);
    note(1, 26);
    note(2, 88);
    note(3, 0);
    note(4, 10'h01F);
    invert = 1'b1;
    settle(120);
    note(5, etm_pkg::ETM_ERR_POL);
    note(6, 1);
    invert = 1'b0;
    settle(120);
    note(6, 0);
    n_tone = 0;
    // long enough to jabber, short enough to leave the peak second unchanged
    hub.send_frame(1000);
    note(5, etm_pkg::ETM_ERR_JABBER);
    note(6, 1);
    note(7, 1);
    note(10, 1);
    settle(2);
    note(6, 0);
    note(5, etm_pkg::ETM_ERR_JABBER);
    note(12, 0);
    wait_tick();
    settle(40);
    note(12, 1);
    audible_en = 1'b0;
    n_tone = 0;
    hub.send_frame(950);
    note(10, 0);
    note(7, 2);
    audible_en = 1'b1;
    link_on = 1'b0;
    n_lost = 0;
    settle(600);
    note(9, 1);
    note(5, etm_pkg::ETM_ERR_NOLINK);
    note(6, 1);
    link_on = 1'b1;
    settle(150);
    // the tone would toggle near the end of this frame: only its own enable mutes it
    tone_en = 1'b0;
    n_tone = 0;
    hub.send_frame(800);
    note(10, 0);
    tone_en = 1'b1;
    stop_cmd = 1'b1;
    settle(1);
    stop_cmd = 1'b0;
    settle(1);
    note(0, 0);
    note(2, 88);
    note(7, 2);
    hist_fix = 1'b1;
    settle(2);
    note(13, 88);
    start_cmd = 1'b1;
    settle(1);
    start_cmd = 1'b0;
    settle(2);
    note(11, '0);
    note(0, 1);
    finish_test();
  end
endmodule : tb_top
